// >>> rtl/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
   // Bus geometry: register indices, byte address is four times the index
   localparam int          ADDR_W       = 18;
   localparam int          IDX_W        = 16;
   localparam logic [15:0] IDX_CSR0     = 16'hffa8; // Also counter write
   localparam logic [15:0] IDX_CNT0     = 16'hffa9;
   localparam logic [15:0] IDX_CSR1     = 16'hffea; // Also counter write
   localparam logic [15:0] IDX_CNT1     = 16'hffeb;
   localparam logic [15:0] IDX_EXT1     = 16'hffec;
   localparam logic [7:0]  KEY_COUNTER  = 8'h5a;
   localparam logic [7:0]  KEY_CONTROL  = 8'ha5;
   localparam logic [1:0]  WORD_STROBE  = 2'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // Control/status and extended selector fields
   localparam int          OVF_BIT      = 7;
   localparam int          MODE_BIT     = 6;
   localparam int          TME_BIT      = 5;
   localparam int          PSS_BIT      = 4;
   localparam int          RST_BIT      = 3;
   localparam int          EXT_EN_BIT   = 7;
   localparam logic [7:0]  CSR_RESET    = 8'h00;
   localparam logic [7:0]  CNT_RESET    = 8'h00;
   localparam logic [7:0]  EXT_RESET    = 8'h00;
   localparam logic [7:0]  EXT_WMASK    = 8'h8f;
   localparam logic [7:0]  COUNT_MAX    = 8'hff;
   // Prescaler widths and internal reset length in system clocks
   localparam int          MAIN_PRE_W   = 21;
   localparam int          SUB_PRE_W    = 12;
   localparam int          RST_CNT_W    = 18;
   localparam int          RESET_CLOCKS_DEF = 131079;

   // Divider exponent for a clock select code, zero when undefined
   function automatic logic [4:0] div_exp(input logic       ch1,
                                          input logic       ext,
                                          input logic       subclock_prescaler_select,
                                          input logic [3:0] code);
      logic [4:0] e;
      e = 5'h00;
      if (!ch1) begin
         case (code[2:0])
            3'h0: e = 5'h01;
            3'h1: e = 5'h06;
            3'h3: e = 5'h09;
            3'h6: e = 5'h0f;
            3'h7: e = 5'h11;
            default: e = 5'h00;
         endcase
      end else if (subclock_prescaler_select) begin
         if (ext ? (code[3:2] != 2'h3)
                 : (code[2:0] != 3'h0 && code[2:0] != 3'h2)) begin
            e = {1'b0, code} + 5'h01;
         end
      end else begin
         case (code)
            4'h0: e = 5'h01;
            4'h1: e = 5'h06;
            4'h2: e = ext ? 5'h07 : 5'h00;
            4'h3: e = 5'h09;
            4'h4: e = 5'h0b;
            4'h5: e = 5'h0d;
            4'h6: e = 5'h0f;
            4'h7: e = 5'h11;
            4'h8: e = 5'h12;
            4'h9: e = 5'h13;
            4'ha: e = 5'h14;
            4'hb: e = 5'h15;
            default: e = 5'h00;
         endcase
      end
      return e;
   endfunction

   // True when the low e bits of a prescaler count are all ones
   function automatic logic tap_hit(input logic [MAIN_PRE_W-1:0] cnt,
                                    input logic [4:0]            e);
      logic [MAIN_PRE_W-1:0] mask;
      mask = MAIN_PRE_W'((64'h1 << e) - 64'h1);
      return (e != 5'h00) && ((cnt & mask) == mask);
   endfunction
endpackage
`default_nettype wire

// >>> rtl/wdt_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_prescaler #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         advance,
   output var  logic [W-1:0] count
);
   if (W < 1) $error("prescaler width must be at least one");

   // Free-running divider chain, taps are read by the channels
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count <= '0;
      end else if (advance) begin
         count <= count + W'(1);
      end
   end

   // Release edge still samples reset high, so it starts no attempt
   a_prescale_step:
   assert property (@(posedge mclk) disable iff (sys_rst)
      !sys_rst && advance |=> count == $past(count) + W'(1))
      else $error("prescaler did not advance");
endmodule
`default_nettype wire

// >>> rtl/wdt_channel.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_channel
   import wdt_pkg::*;
#(
   parameter bit HAS_SUB = 1'b0
) (
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic [MAIN_PRE_W-1:0] main_count,
   input  wire logic [MAIN_PRE_W-1:0] sub_count,
   input  wire logic                  sub_advance,
   input  wire logic [7:0]            ext_select,
   input  wire logic                  write_counter,
   input  wire logic                  write_control,
   input  wire logic [7:0]            write_data,
   input  wire logic                  control_read,
   input  wire logic                  internal_reset,
   output var  logic [7:0]            counter,
   output var  logic [7:0]            control_status,
   output var  logic                  overflow
);
   logic       ovf;
   logic [6:0] csr_low;
   logic       armed;
   logic       timer_run_enable;
   logic       subclock_prescaler_select;
   logic       ext_en;
   logic [4:0] exp_sel;
   logic       tick;
   logic       clear_ovf;

   assign timer_run_enable = csr_low[TME_BIT];
   assign subclock_prescaler_select = HAS_SUB && csr_low[PSS_BIT];
   assign ext_en = HAS_SUB && ext_select[EXT_EN_BIT];
   assign control_status = {ovf, csr_low};

   // Pick the divider tap; sub taps count only on a sub-clock edge
   assign exp_sel = div_exp(HAS_SUB, ext_en, subclock_prescaler_select,
                            ext_en ? ext_select[3:0] : {1'b0, csr_low[2:0]});
   assign tick = subclock_prescaler_select ? (sub_advance && tap_hit(sub_count, exp_sel))
                     : tap_hit(main_count, exp_sel);
   // Wrap from all ones to zero, a counter write suppresses it
   assign overflow = timer_run_enable && tick && !write_counter
                     && counter == COUNT_MAX;

   // Counter: cleared while stopped, write beats increment
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         counter <= CNT_RESET;
      end else if (!timer_run_enable) begin
         counter <= CNT_RESET;
      end else if (write_counter) begin
         counter <= write_data;
      end else if (tick) begin
         counter <= counter + 8'h01;
      end
   end

   // Mode, run enable, action and clock select fields
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         csr_low <= CSR_RESET[6:0];
      end else if (write_control) begin
         csr_low <= write_data[6:0];
      end
   end

   // Flag clear needs a prior read at one, a stop or an internal reset; set wins
   assign clear_ovf = internal_reset
      || (write_control && !write_data[TME_BIT])
      || (write_control && armed && !write_data[OVF_BIT]);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ovf <= CSR_RESET[OVF_BIT];
      end else if (overflow) begin
         ovf <= 1'b1;
      end else if (clear_ovf) begin
         ovf <= 1'b0;
      end
   end

   // Remembers that the flag was seen at one by a read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         armed <= 1'b0;
      end else if (control_read && ovf) begin
         armed <= 1'b1;
      end else if (write_control || !ovf) begin
         armed <= 1'b0;
      end
   end

   a_stop_clears:
   assert property (@(posedge mclk) disable iff (sys_rst)
      !timer_run_enable |=> counter == CNT_RESET)
      else $error("counter not cleared while stopped");
   a_wrap_sets:
   assert property (@(posedge mclk) disable iff (sys_rst)
      overflow |=> ovf && counter == CNT_RESET)
      else $error("overflow did not set flag");
   a_write_wins:
   assert property (@(posedge mclk) disable iff (sys_rst)
      timer_run_enable && write_counter |=> counter == $past(write_data))
      else $error("counter write lost");
   a_count_step:
   assert property (@(posedge mclk) disable iff (sys_rst)
      timer_run_enable && tick && !write_counter && !write_control
      |=> counter == $past(counter) + 8'h01)
      else $error("counter missed a tick");
   a_count_hold:
   assert property (@(posedge mclk) disable iff (sys_rst)
      timer_run_enable && !tick && !write_counter && !write_control |=> $stable(counter))
      else $error("counter moved without tick");
   a_flag_no_set:
   assert property (@(posedge mclk) disable iff (sys_rst)
      !ovf && !overflow |=> !ovf)
      else $error("flag set without overflow");
   a_stop_flag:
   assert property (@(posedge mclk) disable iff (sys_rst)
      write_control && !write_data[TME_BIT] && !overflow |=> !ovf)
      else $error("stop did not clear flag");
endmodule
`default_nettype wire

// >>> rtl/wdt_top.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_top
   import wdt_pkg::*;
#(
   parameter int RESET_CLOCKS = RESET_CLOCKS_DEF
) (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   input  wire logic              sub_clock_input,
   output var  logic              internal_reset_req,
   output var  logic [1:0]        nmi_req,
   output var  logic [1:0]        interval_overflow_interrupt
);
   if (RESET_CLOCKS < 1 || RESET_CLOCKS >= (1 << RST_CNT_W))
      $error("RESET_CLOCKS out of range");

   logic [ADDR_W-1:0]     aw_addr;
   logic [15:0]           w_data;
   logic [1:0]            w_strb;
   logic [IDX_W-1:0]      wr_index;
   logic [IDX_W-1:0]      rd_index;
   logic                  do_write;
   logic                  word_ok;
   logic [7:0]            key;
   logic                  wr_mapped;
   logic [1:0]            wr_cnt;
   logic [1:0]            wr_ctl;
   logic                  wr_ext;
   logic [1:0]            rd_ctl;
   logic                  rd_take;
   logic [31:0]           next_rdata;
   logic [1:0]            next_rresp;
   logic [7:0]            ext_sel;
   logic                  sub_prev;
   logic                  sub_edge;
   logic [MAIN_PRE_W-1:0] main_cnt;
   logic [SUB_PRE_W-1:0]  sub_cnt;
   logic [7:0]            cnt      [2];
   logic [7:0]            csr      [2];
   logic [1:0]            wrap;
   logic [1:0]            rst_hit;
   logic [RST_CNT_W-1:0]  reset_left;
   logic [RST_CNT_W-1:0]  next_left;

   // Write channel: address and data are taken in either order
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awready <= 1'b1;
         aw_addr <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_addr <= awaddr;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wready <= 1'b1;
         w_data <= 16'h0000;
         w_strb <= 2'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_data <= wdata[15:0];
         w_strb <= wstrb[1:0];
      end else if (bvalid && bready) begin
         wready <= 1'b1;
      end
   end

   // Keyed word writes; counter and control share one index
   assign do_write  = !awready && !wready && !bvalid;
   assign wr_index  = aw_addr[ADDR_W-1:2];
   assign word_ok   = w_strb == WORD_STROBE;
   assign key       = w_data[15:8];
   assign wr_mapped = wr_index == IDX_CSR0 || wr_index == IDX_CSR1
                      || wr_index == IDX_EXT1;
   assign wr_cnt[0] = do_write && word_ok && wr_index == IDX_CSR0
                      && key == KEY_COUNTER;
   assign wr_cnt[1] = do_write && word_ok && wr_index == IDX_CSR1
                      && key == KEY_COUNTER;
   assign wr_ctl[0] = do_write && word_ok && wr_index == IDX_CSR0
                      && key == KEY_CONTROL;
   assign wr_ctl[1] = do_write && word_ok && wr_index == IDX_CSR1
                      && key == KEY_CONTROL;
   assign wr_ext    = do_write && word_ok && wr_index == IDX_EXT1
                      && key == KEY_CONTROL;

   // Write response, unmapped index answers with an error
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read side: counters sit one index (four bytes) above their control registers
   assign rd_index  = araddr[ADDR_W-1:2];
   assign rd_take   = arvalid && arready;
   assign rd_ctl[0] = rd_take && rd_index == IDX_CSR0;
   assign rd_ctl[1] = rd_take && rd_index == IDX_CSR1;

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      case (rd_index)
         IDX_CSR0: next_rdata[7:0] = csr[0];
         IDX_CNT0: next_rdata[7:0] = cnt[0];
         IDX_CSR1: next_rdata[7:0] = csr[1];
         IDX_CNT1: next_rdata[7:0] = cnt[1];
         IDX_EXT1: next_rdata[7:0] = ext_sel;
         default:  next_rresp = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (rd_take) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // Extended clock selector for channel 1, reserved bits kept zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ext_sel <= EXT_RESET;
      end else if (wr_ext) begin
         ext_sel <= w_data[7:0] & EXT_WMASK;
      end
   end

   // Sub-clock rising edge advances the sub-clock prescaler
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sub_prev <= 1'b0;
      end else begin
         sub_prev <= sub_clock_input;
      end
   end
   assign sub_edge = sub_clock_input && !sub_prev;

   wdt_prescaler #(.W(MAIN_PRE_W)) u_main_pre (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .advance (1'b1),
      .count   (main_cnt)
   );

   wdt_prescaler #(.W(SUB_PRE_W)) u_sub_pre (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .advance (sub_edge),
      .count   (sub_cnt)
   );

   // Two channels of one module, only channel 1 sees the sub-clock
   for (genvar i = 0; i < 2; i++) begin : g_ch
      wdt_channel #(.HAS_SUB(i == 1)) u_ch (
         .mclk           (mclk),
         .sys_rst        (sys_rst),
         .main_count     (main_cnt),
         .sub_count      (MAIN_PRE_W'(sub_cnt)),
         .sub_advance    (sub_edge),
         .ext_select     ((i == 1) ? ext_sel : EXT_RESET),
         .write_counter  (wr_cnt[i]),
         .write_control  (wr_ctl[i]),
         .write_data     (w_data[7:0]),
         .control_read   (rd_ctl[i]),
         .internal_reset (internal_reset_req),
         .counter        (cnt[i]),
         .control_status (csr[i]),
         .overflow       (wrap[i])
      );
      assign rst_hit[i] = wrap[i] && csr[i][MODE_BIT]
                          && csr[i][RST_BIT];

      // NMI pulse on watchdog overflow when reset is not chosen
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            nmi_req[i] <= 1'b0;
         end else begin
            nmi_req[i] <= wrap[i] && csr[i][MODE_BIT]
                          && !csr[i][RST_BIT];
         end
      end

      // Interval interrupt follows the flag in interval mode
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            interval_overflow_interrupt[i] <= 1'b0;
         end else begin
            interval_overflow_interrupt[i] <= csr[i][OVF_BIT]
                                              && !csr[i][MODE_BIT];
         end
      end

      a_nmi_pulse:
      assert property (@(posedge mclk) disable iff (sys_rst)
         wrap[i] && csr[i][MODE_BIT] && !csr[i][RST_BIT]
         |=> nmi_req[i] ##1 !nmi_req[i] || wrap[i])
         else $error("NMI request missing after overflow");
      a_interval_irq:
      assert property (@(posedge mclk) disable iff (sys_rst)
         wrap[i] && !csr[i][MODE_BIT] |=> ##1 interval_overflow_interrupt[i])
         else $error("interval interrupt missing after overflow");
   end

   // Internal reset stretcher, retriggered by a later overflow
   always_comb begin
      if (rst_hit != 2'h0) begin
         next_left = RST_CNT_W'(RESET_CLOCKS);
      end else if (reset_left != '0) begin
         next_left = reset_left - RST_CNT_W'(1);
      end else begin
         next_left = reset_left;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reset_left         <= '0;
         internal_reset_req <= 1'b0;
      end else begin
         reset_left         <= next_left;
         internal_reset_req <= next_left != '0;
      end
   end

   a_reset_start:
   assert property (@(posedge mclk) disable iff (sys_rst)
      rst_hit != 2'h0 |=> internal_reset_req
      && reset_left == RST_CNT_W'(RESET_CLOCKS))
      else $error("internal reset did not start");
   a_reset_hold:
   assert property (@(posedge mclk) disable iff (sys_rst)
      reset_left > RST_CNT_W'(1) |=> internal_reset_req)
      else $error("internal reset ended early");
   a_reset_end:
   assert property (@(posedge mclk) disable iff (sys_rst)
      reset_left == RST_CNT_W'(1) && rst_hit == 2'h0
      |=> !internal_reset_req)
      else $error("internal reset too long");
   a_reset_flag:
   assert property (@(posedge mclk) disable iff (sys_rst)
      internal_reset_req && wrap == 2'h0
      |=> !csr[0][OVF_BIT] && !csr[1][OVF_BIT])
      else $error("flag survived internal reset");
endmodule
`default_nettype wire

// >>> tb/tb_wdt_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_wdt_top
   import wdt_pkg::*;
;
   logic              mclk = 1'b0;
   logic              sys_rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0;
   logic [3:0]        wstrb = '0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              sub_clock_input = 1'b0, sub_run = 1'b0;
   logic [1:0]        sub_div = '0;
   logic              awready, wready, bvalid, arready, rvalid, irst;
   logic [1:0]        bresp, rresp, nmi, irq;
   logic [31:0]       rdata;
   int                miscompares = 0, n_compared = 0;

   wdt_top #(.RESET_CLOCKS(8)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sub_clock_input(sub_clock_input), .internal_reset_req(irst),
      .nmi_req(nmi), .interval_overflow_interrupt(irq));

   // System clock, 100 ns period
   always #50 mclk = ~mclk;

   // Sub-clock, one rising edge every eight system clocks while enabled
   always @(posedge mclk) begin
      sub_div <= sub_div + 2'h1;
      if (sub_run && sub_div == 2'h3) sub_clock_input <= ~sub_clock_input;
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Keyed word write: key in the upper byte, data in the lower byte
   task automatic wr(input logic [15:0] idx, input logic [7:0] key,
                     input logic [7:0] d, input logic [3:0] st,
                     input logic [1:0] er);
      @(posedge mclk);
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, key, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1); // A hang is ended by the watchdog
      bready <= 1'b0;
      check("bvalid", 32'h1, {31'h0, bvalid});
      check("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] exp,
                     input logic [1:0] er);
      @(posedge mclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1); // A hang is ended by the watchdog
      rready <= 1'b0;
      check("rvalid", 32'h1, {31'h0, rvalid});
      check("rresp", {30'h0, er}, {30'h0, rresp});
      if (er === RESP_OKAY) check("rdata", {24'h0, exp}, rdata);
   endtask

   // Wait, bounded, for one of the event outputs to go high
   task automatic wait_hi(input int sel, input string what);
      int n;
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         case (sel)
            0: s = irq[0];
            1: s = nmi[1];
            2: s = irst;
            default: s = irq[1];
         endcase
         n++;
      end
      check(what, 32'h1, {31'h0, s});
   endtask

   task automatic t_reset_values();
      rd(IDX_CSR0, 8'h00, RESP_OKAY);
      rd(IDX_CNT0, 8'h00, RESP_OKAY);
      rd(IDX_CSR1, 8'h00, RESP_OKAY);
      rd(IDX_CNT1, 8'h00, RESP_OKAY);
      rd(IDX_EXT1, 8'h00, RESP_OKAY);
      rd(16'h0100, 8'h00, RESP_SLVERR);
      wr(16'h0100, KEY_CONTROL, 8'h20, 4'h3, RESP_SLVERR);
   endtask

   task automatic t_protected();
      wr(IDX_CSR0, 8'h00, 8'h27, 4'h3, RESP_OKAY);
      rd(IDX_CSR0, 8'h00, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h27, 4'h1, RESP_OKAY);
      rd(IDX_CSR0, 8'h00, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h27, 4'h3, RESP_OKAY);
      wr(IDX_CSR0, KEY_COUNTER, 8'hc3, 4'h3, RESP_OKAY);
      rd(IDX_CNT0, 8'hc3, RESP_OKAY);
      rd(IDX_CSR0, 8'h27, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h07, 4'h3, RESP_OKAY);
      rd(IDX_CNT0, 8'h00, RESP_OKAY);
      wr(IDX_EXT1, KEY_COUNTER, 8'h81, 4'h3, RESP_OKAY);
      rd(IDX_EXT1, 8'h00, RESP_OKAY);
      wr(IDX_EXT1, KEY_CONTROL, 8'hff, 4'h3, RESP_OKAY);
      rd(IDX_EXT1, 8'h8f, RESP_OKAY);
      wr(IDX_EXT1, KEY_CONTROL, 8'h00, 4'h3, RESP_OKAY);
   endtask

   // Interval overflow, then the read-before-clear sequence on the flag
   task automatic t_interval();
      wr(IDX_CSR0, KEY_CONTROL, 8'h20, 4'h3, RESP_OKAY);
      wr(IDX_CSR0, KEY_COUNTER, 8'hfe, 4'h3, RESP_OKAY);
      wait_hi(0, "irq0");
      wr(IDX_CSR0, KEY_CONTROL, 8'h20, 4'h3, RESP_OKAY);
      rd(IDX_CSR0, 8'ha0, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h20, 4'h3, RESP_OKAY);
      rd(IDX_CSR0, 8'h20, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h00, 4'h3, RESP_OKAY);
   endtask

   task automatic t_nmi();
      wr(IDX_CSR1, KEY_CONTROL, 8'h60, 4'h3, RESP_OKAY);
      wr(IDX_CSR1, KEY_COUNTER, 8'hff, 4'h3, RESP_OKAY);
      wait_hi(1, "nmi1");
      check("irq1", 32'h0, {31'h0, irq[1]});
      rd(IDX_CSR1, 8'he0, RESP_OKAY);
      wr(IDX_CSR1, KEY_CONTROL, 8'h40, 4'h3, RESP_OKAY);
      rd(IDX_CSR1, 8'h40, RESP_OKAY);
   endtask

   // Reset action: length of the request and the flag cleared by it
   task automatic t_reset_mode();
      int cnt;
      cnt = 0;
      wr(IDX_CSR0, KEY_CONTROL, 8'h68, 4'h3, RESP_OKAY);
      wr(IDX_CSR0, KEY_COUNTER, 8'hff, 4'h3, RESP_OKAY);
      wait_hi(2, "irst");
      check("nmi0", 32'h0, {31'h0, nmi[0]});
      while (irst === 1'b1 && cnt < 100) begin
         cnt++;
         @(negedge mclk);
      end
      check("irst length", 32'd8, cnt);
      rd(IDX_CSR0, 8'h68, RESP_OKAY);
      wr(IDX_CSR0, KEY_CONTROL, 8'h00, 4'h3, RESP_OKAY);
   endtask

   // Sub-clock source: still while the pin is idle, counts when it runs
   task automatic t_sub();
      wr(IDX_CSR1, KEY_CONTROL, 8'h31, 4'h3, RESP_OKAY);
      wr(IDX_CSR1, KEY_COUNTER, 8'hfe, 4'h3, RESP_OKAY);
      rd(IDX_CNT1, 8'hfe, RESP_OKAY);
      rd(IDX_CNT1, 8'hfe, RESP_OKAY);
      sub_run <= 1'b1;
      wait_hi(3, "irq1");
      rd(IDX_CSR1, 8'hb1, RESP_OKAY);
      wr(IDX_CSR1, KEY_CONTROL, 8'h00, 4'h3, RESP_OKAY);
      sub_run <= 1'b0;
   endtask

   task automatic stop_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset_values();
      t_protected();
      t_interval();
      t_nmi();
      t_reset_mode();
      t_sub();
      stop_test();
   end

   // Watchdog against a hang
   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire
